// ===== design/mie_map.vh
`ifndef MIE_MAP_VH
`define MIE_MAP_VH
`define MIE_OP_NONE 5'h00
`define MIE_OP_IRQ_EXIT 5'h01
`define MIE_OP_SUB_EXIT_LOAD 5'h02
`define MIE_OP_ROT_L 5'h03
`define MIE_OP_ROT_LC 5'h04
`define MIE_OP_ROT_R 5'h05
`define MIE_OP_ROT_RC 5'h06
`define MIE_OP_SUB_BORROW 5'h07
`define MIE_OP_SUB_MEM 5'h08
`define MIE_OP_SUB_IMM 5'h09
`define MIE_OP_DEC_SKIP 5'h0a
`define MIE_OP_INC_SKIP 5'h0b
`define MIE_OP_BIT_SKIP_NZ 5'h0c
`define MIE_OP_BIT_SKIP_Z 5'h0d
`define MIE_OP_BYTE_SKIP_Z 5'h0e
`define MIE_OP_COPY_SKIP_Z 5'h0f
`define MIE_OP_FILL 5'h10
`define MIE_OP_FILL_BIT 5'h11
`define MIE_OP_NIBBLE 5'h12
`define MIE_OP_TAB_FETCH 5'h13
`define MIE_OP_TAB_LAST 5'h14
`define MIE_OP_XOR_MEM 5'h15
`define MIE_OP_XOR_IMM 5'h16
`define MIE_RST_WORK 8'h00
`define MIE_RST_FLAGS 4'h0
`define MIE_FLAG_C 0
`define MIE_FLAG_AC 1
`define MIE_FLAG_Z 2
`define MIE_FLAG_OV 3
`define MIE_CYCLES_SKIP 2'h2
`endif

// ===== design/mie_sub_unit.v
`timescale 1ns/100ps
`default_nettype none
module mie_sub_unit (
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  input wire borrow_in_n,
  output reg [7:0] diff,
  output reg carry_out,
  output reg half_out,
  output reg wrap_out
);
  reg [8:0] full;
  reg [4:0] low;
  always @* begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, borrow_in_n};
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, borrow_in_n};
    diff = full[7:0];
    // Carry set means no borrow, so a negative result clears it.
    carry_out = full[8];
    half_out = low[4];
    wrap_out = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
  end
endmodule
`default_nettype wire

// ===== design/mie_rot_unit.v
`timescale 1ns/100ps
`default_nettype none
module mie_rot_unit (
  input wire [7:0] value,
  input wire carry_in,
  input wire left,
  input wire via_carry,
  output reg [7:0] result,
  output reg carry_out
);
  always @* begin
    if (left) begin
      result = {value[6:0], via_carry ? carry_in : value[7]};
      carry_out = via_carry ? value[7] : carry_in;
    end else begin
      result = {via_carry ? carry_in : value[0], value[7:1]};
      carry_out = via_carry ? value[0] : carry_in;
    end
  end
endmodule
`default_nettype wire

// ===== design/mie_exec.v
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mie_map.vh"
module mie_exec #(
  parameter PC_W = 11,
  parameter PROG_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [4:0] op_code,
  input wire to_work,
  input wire [2:0] bit_sel,
  input wire [7:0] imm_data,
  input wire [7:0] mem_rdata,
  input wire [PC_W-1:0] stack_top,
  input wire [PC_W-1:0] pc_current,
  input wire irq_pending,
  input wire [7:0] table_ptr_high,
  input wire [7:0] table_ptr_low,
  input wire [PROG_W-1:0] prog_rdata,
  output wire busy,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  output reg [PROG_W-1:0] prog_addr,
  output reg stack_pop,
  output reg pc_load,
  output reg [PC_W-1:0] pc_next,
  output reg skip_next,
  output reg irq_service,
  output reg [7:0] working_register,
  output reg master_irq_enable,
  output reg borrow_out_bit,
  output reg half_carry,
  output reg null_result_flag,
  output reg signed_wrap_flag,
  output reg [7:0] table_high_latch
);

  // --------------------------------------------------------------
  // Datapath units
  // --------------------------------------------------------------
  wire [7:0] sub_rhs;
  wire sub_bin;
  wire [7:0] sub_diff;
  wire sub_c;
  wire sub_ac;
  wire sub_ov;
  wire [7:0] rot_res;
  wire rot_c;
  wire rot_left;
  wire rot_via;

  // Both immediate forms share this mux, so subtract and exclusive-or pick the same operand source.
  assign sub_rhs = ((op_code == `MIE_OP_SUB_IMM) || (op_code == `MIE_OP_XOR_IMM)) ? imm_data : mem_rdata;
  // Plain subtraction feeds a fixed carry-in of one, so it shares the adder.
  assign sub_bin = (op_code == `MIE_OP_SUB_BORROW) ? borrow_out_bit : 1'b1;
  assign rot_left = (op_code == `MIE_OP_ROT_L) || (op_code == `MIE_OP_ROT_LC);
  assign rot_via = (op_code == `MIE_OP_ROT_LC) || (op_code == `MIE_OP_ROT_RC);

  mie_sub_unit u_sub (
    .minuend(working_register),
    .subtrahend(sub_rhs),
    .borrow_in_n(sub_bin),
    .diff(sub_diff),
    .carry_out(sub_c),
    .half_out(sub_ac),
    .wrap_out(sub_ov)
  );

  mie_rot_unit u_rot (
    .value(mem_rdata),
    .carry_in(borrow_out_bit),
    .left(rot_left),
    .via_carry(rot_via),
    .result(rot_res),
    .carry_out(rot_c)
  );

  // --------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_DUMMY = 1'b1;

  reg state_q;
  reg [PROG_W-1:0] tab_addr;
  reg do_skip;
  reg is_skip_op;
  reg is_table;
  reg [7:0] incdec;

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  // The dummy cycle holds off the core so a skipped fetch is discarded.
  assign busy = (state_q == ST_DUMMY);

  always @* begin
    tab_addr = {PROG_W{1'b0}};
    tab_addr[15:0] = {table_ptr_high, table_ptr_low};
    if (op_code == `MIE_OP_TAB_LAST) begin
      // Last page means all upper address bits high.
      tab_addr = {PROG_W{1'b1}};
      tab_addr[7:0] = table_ptr_low;
    end
  end

  always @* begin
    incdec = (op_code == `MIE_OP_DEC_SKIP) ? (mem_rdata - 8'h01) : (mem_rdata + 8'h01);
    is_table = (op_code == `MIE_OP_TAB_FETCH) || (op_code == `MIE_OP_TAB_LAST);
    is_skip_op = 1'b0;
    do_skip = 1'b0;
    case (op_code)
      `MIE_OP_DEC_SKIP, `MIE_OP_INC_SKIP: begin
        is_skip_op = 1'b1;
        do_skip = is_zero(incdec);
      end
      `MIE_OP_BIT_SKIP_NZ: begin
        is_skip_op = 1'b1;
        do_skip = mem_rdata[bit_sel];
      end
      `MIE_OP_BIT_SKIP_Z: begin
        is_skip_op = 1'b1;
        do_skip = ~mem_rdata[bit_sel];
      end
      `MIE_OP_BYTE_SKIP_Z, `MIE_OP_COPY_SKIP_Z: begin
        is_skip_op = 1'b1;
        do_skip = is_zero(mem_rdata);
      end
      default: begin
        is_skip_op = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (instr_valid && is_skip_op && do_skip) begin
            state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Execution
  // --------------------------------------------------------------
  wire take;
  assign take = instr_valid && (state_q == ST_IDLE);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      prog_addr <= {PROG_W{1'b0}};
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_next <= {PC_W{1'b0}};
      skip_next <= 1'b0;
      irq_service <= 1'b0;
      working_register <= `MIE_RST_WORK;
      master_irq_enable <= 1'b0;
      borrow_out_bit <= 1'b0;
      half_carry <= 1'b0;
      null_result_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      table_high_latch <= 8'h00;
    end else begin
      mem_we <= 1'b0;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      skip_next <= 1'b0;
      irq_service <= 1'b0;
      if (take) begin
        if (is_table) begin
          prog_addr <= tab_addr;
        end
        skip_next <= is_skip_op && do_skip;
        case (op_code)
          `MIE_OP_IRQ_EXIT: begin
            stack_pop <= 1'b1;
            pc_load <= 1'b1;
            pc_next <= stack_top;
            master_irq_enable <= 1'b1;
            // The core vectors to the pending handler instead of the popped address.
            irq_service <= irq_pending;
          end
          `MIE_OP_SUB_EXIT_LOAD: begin
            stack_pop <= 1'b1;
            pc_load <= 1'b1;
            pc_next <= stack_top;
            working_register <= imm_data;
          end
          `MIE_OP_ROT_L, `MIE_OP_ROT_LC, `MIE_OP_ROT_R, `MIE_OP_ROT_RC: begin
            if (to_work) begin
              working_register <= rot_res;
            end else begin
              mem_we <= 1'b1;
              mem_wdata <= rot_res;
            end
            borrow_out_bit <= rot_c;
          end
          `MIE_OP_SUB_BORROW, `MIE_OP_SUB_MEM, `MIE_OP_SUB_IMM: begin
            if (to_work || op_code == `MIE_OP_SUB_IMM) begin
              working_register <= sub_diff;
            end else begin
              mem_we <= 1'b1;
              mem_wdata <= sub_diff;
            end
            borrow_out_bit <= sub_c;
            half_carry <= sub_ac;
            signed_wrap_flag <= sub_ov;
            null_result_flag <= is_zero(sub_diff);
          end
          `MIE_OP_DEC_SKIP, `MIE_OP_INC_SKIP: begin
            if (to_work) begin
              working_register <= incdec;
            end else begin
              mem_we <= 1'b1;
              mem_wdata <= incdec;
            end
          end
          `MIE_OP_COPY_SKIP_Z: begin
            working_register <= mem_rdata;
          end
          `MIE_OP_FILL: begin
            mem_we <= 1'b1;
            mem_wdata <= 8'hff;
          end
          `MIE_OP_FILL_BIT: begin
            mem_we <= 1'b1;
            mem_wdata <= mem_rdata | (8'h01 << bit_sel);
          end
          `MIE_OP_NIBBLE: begin
            if (to_work) begin
              working_register <= {mem_rdata[3:0], mem_rdata[7:4]};
            end else begin
              mem_we <= 1'b1;
              mem_wdata <= {mem_rdata[3:0], mem_rdata[7:4]};
            end
          end
          `MIE_OP_XOR_MEM, `MIE_OP_XOR_IMM: begin
            if (op_code == `MIE_OP_XOR_MEM && !to_work) begin
              mem_we <= 1'b1;
              mem_wdata <= working_register ^ mem_rdata;
              null_result_flag <= is_zero(working_register ^ mem_rdata);
            end else begin
              working_register <= working_register ^ sub_rhs;
              null_result_flag <= is_zero(working_register ^ sub_rhs);
            end
          end
          default: begin
            mem_we <= 1'b0;
          end
        endcase
      end else if (state_q == ST_IDLE && is_table) begin
        prog_addr <= tab_addr;
      end
    end
  end

  // --------------------------------------------------------------
  // Table word capture
  // --------------------------------------------------------------
  // Program memory answers within the cycle of the registered address, so the word is latched on the next edge.
  reg tab_pend_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tab_pend_q <= 1'b0;
    end else begin
      tab_pend_q <= take && is_table;
      if (tab_pend_q) begin
        table_high_latch <= prog_rdata[PROG_W-1:8];
      end
    end
  end

  wire unused_ok;
  assign unused_ok = ^pc_current;
endmodule
`default_nettype wire

// ===== dv/mie_prog_model.sv
`timescale 1ns/100ps
`default_nettype none
module mie_prog_model #(
  parameter PROG_W = 16
) (
  input wire [PROG_W-1:0] prog_addr,
  output logic [PROG_W-1:0] prog_rdata
);
  // ----------
  // Program store
  // ----------
  // The word follows the registered address within its cycle, so the core takes it on the next edge.
  // High byte is keyed on the low address byte and low byte mirrors the page.
  assign prog_rdata = PROG_W'({prog_addr[7:0] ^ 8'h3c, prog_addr[15:8]});
endmodule
`default_nettype wire

// ===== dv/mie_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "mie_map.vh"
module mie_exec_sva #(
  parameter PC_W = 11,
  parameter PROG_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [4:0] op_code,
  input wire to_work,
  input wire [7:0] imm_data,
  input wire [7:0] mem_rdata,
  input wire [PC_W-1:0] stack_top,
  input wire irq_pending,
  input wire [7:0] table_ptr_low,
  input wire busy,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  input wire [PROG_W-1:0] prog_addr,
  input wire pc_load,
  input wire [PC_W-1:0] pc_next,
  input wire skip_next,
  input wire irq_service,
  input wire [7:0] working_register,
  input wire borrow_out_bit,
  input wire master_irq_enable
);
  // ----------
  // Checks
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Operand and carry are kept a cycle so each check sees what the instruction consumed.
  logic [7:0] m_q;
  logic c_q;
  always @(posedge clk) begin
    m_q <= mem_rdata;
    c_q <= borrow_out_bit;
  end
  wire go = instr_valid && !busy;
  AST_IRQ_EXIT: assert property (go && op_code == `MIE_OP_IRQ_EXIT |=>
    pc_load && master_irq_enable && pc_next == $past(stack_top)) else $error("irq exit");
  AST_IRQ_SVC: assert property (go && op_code == `MIE_OP_IRQ_EXIT && irq_pending |=> irq_service)
    else $error("pending irq");
  AST_SUB_EXIT: assert property (go && op_code == `MIE_OP_SUB_EXIT_LOAD |=>
    pc_load && working_register == $past(imm_data)) else $error("sub exit");
  AST_ROT_L: assert property (go && op_code == `MIE_OP_ROT_L && !to_work |=>
    mem_we && mem_wdata == {m_q[6:0], m_q[7]}) else $error("rotate left");
  AST_ROT_RC: assert property (go && op_code == `MIE_OP_ROT_RC && !to_work |=>
    mem_wdata == {c_q, m_q[7:1]} && borrow_out_bit == m_q[0]) else $error("rotate right carry");
  AST_SKIP_BUSY: assert property (skip_next |-> busy ##1 !busy)
    else $error("skip length");
  AST_FILL: assert property (go && op_code == `MIE_OP_FILL |=> mem_we && mem_wdata == 8'hff)
    else $error("fill");
  AST_NIBBLE: assert property (go && op_code == `MIE_OP_NIBBLE && to_work |=>
    !mem_we && working_register == {m_q[3:0], m_q[7:4]}) else $error("nibble");
  AST_TAB_LAST: assert property (go && op_code == `MIE_OP_TAB_LAST |=>
    prog_addr[15:8] == 8'hff && prog_addr[7:0] == $past(table_ptr_low)) else $error("last page");
  AST_XOR_C: assert property (go && op_code == `MIE_OP_XOR_IMM |=> $stable(borrow_out_bit))
    else $error("xor carry");
  cover property (skip_next);
  cover property (irq_service);
  cover property (mem_we && mem_wdata == 8'hff);
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mie_map.vh"
module tb;
  logic clk = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0, to_work = 1'h0, irq_pending = 1'h0;
  logic [4:0] op_code = 5'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] imm_data = 8'h00, mem_rdata = 8'h00, table_ptr_high = 8'h00, table_ptr_low = 8'h00;
  logic [10:0] stack_top = 11'h000;
  wire [15:0] prog_addr, prog_rdata;
  wire busy, mem_we, stack_pop, pc_load, skip_next, irq_service, master_irq_enable, borrow_out_bit;
  wire half_carry, null_result_flag, signed_wrap_flag;
  wire [7:0] mem_wdata, working_register, table_high_latch;
  wire [10:0] pc_next;
  int mismatches = 0, n_checks = 0, cycles = 0;
  always #4 clk = ~clk;
  mie_exec uut (
    .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .op_code(op_code), .to_work(to_work),
    .bit_sel(bit_sel), .imm_data(imm_data), .mem_rdata(mem_rdata), .stack_top(stack_top), .pc_current(11'h000),
    .irq_pending(irq_pending), .table_ptr_high(table_ptr_high), .table_ptr_low(table_ptr_low),
    .prog_rdata(prog_rdata), .busy(busy), .mem_we(mem_we), .mem_wdata(mem_wdata), .prog_addr(prog_addr),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_next(pc_next), .skip_next(skip_next), .irq_service(irq_service),
    .working_register(working_register), .master_irq_enable(master_irq_enable), .borrow_out_bit(borrow_out_bit),
    .half_carry(half_carry), .null_result_flag(null_result_flag), .signed_wrap_flag(signed_wrap_flag),
    .table_high_latch(table_high_latch)
  );
  mie_prog_model pm (.prog_addr(prog_addr), .prog_rdata(prog_rdata));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Immediate forms get the inverse on the memory operand and the rest the reverse, so a wrong source shows.
  task automatic run(input logic [4:0] op, input logic tw, input logic [2:0] bs, input logic [7:0] v);
    logic imm_op;
    imm_op = (op == `MIE_OP_SUB_IMM) || (op == `MIE_OP_XOR_IMM) || (op == `MIE_OP_SUB_EXIT_LOAD);
    @(posedge clk);
    op_code <= op;
    to_work <= tw;
    bit_sel <= bs;
    imm_data <= imm_op ? v : ~v;
    mem_rdata <= imm_op ? ~v : v;
    instr_valid <= 1'h1;
    @(posedge clk);
    instr_valid <= 1'h0;
    #1;
  endtask
  task automatic sk(input logic [4:0] op, input logic tw, input logic [2:0] bs, input logic [7:0] v, input logic s);
    run(op, tw, bs, v);
    chk("skip", {skip_next, busy}, {s, s});
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_ret;
    @(posedge clk);
    stack_top <= 11'h5a3;
    irq_pending <= 1'h1;
    run(`MIE_OP_IRQ_EXIT, 1'h0, 3'h0, 8'h00);
    chk("pc", pc_next, 11'h5a3);
    chk("irq", {pc_load, stack_pop, master_irq_enable, irq_service}, 4'hf);
    @(posedge clk);
    stack_top <= 11'h21c;
    irq_pending <= 1'h0;
    run(`MIE_OP_IRQ_EXIT, 1'h0, 3'h0, 8'h00);
    chk("irq_idle", {pc_next, pc_load, irq_service}, 13'h0872);
    run(`MIE_OP_SUB_EXIT_LOAD, 1'h0, 3'h0, 8'h3c);
    chk("ret", {pc_load, working_register}, 9'h13c);
  endtask
  task automatic t_sub;
    run(`MIE_OP_SUB_EXIT_LOAD, 1'h0, 3'h0, 8'h10);
    run(`MIE_OP_SUB_MEM, 1'h1, 3'h0, 8'h20);
    chk("sub", {working_register, borrow_out_bit, null_result_flag, signed_wrap_flag}, 11'h780);
    chk("sub_ac", half_carry, 1'h1);
    run(`MIE_OP_SUB_BORROW, 1'h0, 3'h0, 8'h05);
    chk("minus_with_borrow_to_mem", {mem_we, mem_wdata}, 9'h1ea);
    chk("minus_with_borrow_to_mem_c", {working_register, borrow_out_bit}, 9'h1e1);
    chk("minus_with_borrow_to_mem_ac", half_carry, 1'h0);
    run(`MIE_OP_SUB_BORROW, 1'h1, 3'h0, 8'h71);
    chk("sbc", {working_register, borrow_out_bit, null_result_flag, signed_wrap_flag}, 11'h3fd);
    run(`MIE_OP_SUB_MEM, 1'h0, 3'h0, 8'h01);
    chk("minus_plain_to_mem", {mem_we, mem_wdata}, 9'h17e);
    chk("minus_plain_to_mem_f", {working_register, borrow_out_bit, null_result_flag, signed_wrap_flag, half_carry}, 12'h7f9);
    run(`MIE_OP_SUB_IMM, 1'h1, 3'h0, 8'h7f);
    chk("subi", {working_register, borrow_out_bit, null_result_flag, signed_wrap_flag}, 11'h006);
  endtask
  task automatic t_rot;
    run(`MIE_OP_ROT_L, 1'h0, 3'h0, 8'h81);
    chk("rl", {mem_we, mem_wdata}, 9'h103);
    run(`MIE_OP_ROT_R, 1'h1, 3'h0, 8'h81);
    chk("rr", {mem_we, working_register}, 9'h0c0);
    run(`MIE_OP_ROT_LC, 1'h1, 3'h0, 8'h81);
    chk("rlc", {working_register, borrow_out_bit}, 9'h007);
    run(`MIE_OP_ROT_RC, 1'h0, 3'h0, 8'h02);
    chk("rrc", {mem_we, mem_wdata, borrow_out_bit}, 10'h302);
  endtask
  task automatic t_skip;
    sk(`MIE_OP_DEC_SKIP, 1'h0, 3'h0, 8'h01, 1'h1);
    chk("dec", {mem_we, mem_wdata}, 9'h100);
    sk(`MIE_OP_DEC_SKIP, 1'h1, 3'h0, 8'h05, 1'h0);
    chk("deca", {mem_we, working_register}, 9'h004);
    sk(`MIE_OP_INC_SKIP, 1'h1, 3'h0, 8'hff, 1'h1);
    chk("inca", working_register, 8'h00);
    sk(`MIE_OP_INC_SKIP, 1'h0, 3'h0, 8'h41, 1'h0);
    chk("inc", {mem_we, mem_wdata}, 9'h142);
    sk(`MIE_OP_BIT_SKIP_NZ, 1'h0, 3'h7, 8'h80, 1'h1);
    sk(`MIE_OP_BIT_SKIP_NZ, 1'h0, 3'h6, 8'hbf, 1'h0);
    sk(`MIE_OP_BIT_SKIP_Z, 1'h0, 3'h6, 8'hbf, 1'h1);
    sk(`MIE_OP_BIT_SKIP_Z, 1'h0, 3'h0, 8'h01, 1'h0);
    sk(`MIE_OP_BYTE_SKIP_Z, 1'h0, 3'h0, 8'h00, 1'h1);
    sk(`MIE_OP_COPY_SKIP_Z, 1'h1, 3'h0, 8'h5c, 1'h0);
    chk("sza", working_register, 8'h5c);
    chk("flags", {borrow_out_bit, null_result_flag, signed_wrap_flag}, 3'h2);
  endtask
  task automatic t_misc;
    run(`MIE_OP_FILL, 1'h0, 3'h0, 8'h12);
    chk("fill", {mem_we, mem_wdata}, 9'h1ff);
    run(`MIE_OP_FILL_BIT, 1'h0, 3'h2, 8'h41);
    chk("fillb", {mem_we, mem_wdata}, 9'h145);
    run(`MIE_OP_NIBBLE, 1'h1, 3'h0, 8'ha5);
    chk("nib", {mem_we, working_register}, 9'h05a);
    run(`MIE_OP_NIBBLE, 1'h0, 3'h0, 8'h3c);
    chk("nibm", {mem_we, mem_wdata}, 9'h1c3);
    run(`MIE_OP_XOR_IMM, 1'h1, 3'h0, 8'h5a);
    chk("xori", {working_register, null_result_flag, borrow_out_bit}, 10'h002);
    run(`MIE_OP_XOR_MEM, 1'h0, 3'h0, 8'h0f);
    chk("exclusive_or_to_mem", {mem_we, mem_wdata, null_result_flag}, 10'h21e);
    @(posedge clk);
    table_ptr_high <= 8'h12;
    table_ptr_low <= 8'h34;
    run(`MIE_OP_TAB_FETCH, 1'h0, 3'h0, 8'h00);
    chk("tab", prog_addr, 16'h1234);
    repeat (3) @(posedge clk);
    table_ptr_low <= 8'h56;
    #1;
    chk("table_high_latch", table_high_latch, 8'h08);
    run(`MIE_OP_TAB_LAST, 1'h0, 3'h0, 8'h00);
    chk("tabl", prog_addr, 16'hff56);
    repeat (3) @(posedge clk);
    #1;
    chk("tblhl", table_high_latch, 8'h6a);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    chk("reset", {working_register, master_irq_enable, borrow_out_bit}, 10'h000);
    sys_rst <= 1'h0;
    t_ret;
    t_sub;
    t_rot;
    t_skip;
    t_misc;
    conclude;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude;
    end
  end
endmodule
bind mie_exec mie_exec_sva #(.PC_W(PC_W), .PROG_W(PROG_W)) sva (
  .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .op_code(op_code), .to_work(to_work),
  .imm_data(imm_data), .mem_rdata(mem_rdata), .stack_top(stack_top), .irq_pending(irq_pending),
  .table_ptr_low(table_ptr_low), .busy(busy), .mem_we(mem_we), .mem_wdata(mem_wdata), .prog_addr(prog_addr),
  .pc_load(pc_load), .pc_next(pc_next), .skip_next(skip_next), .irq_service(irq_service),
  .working_register(working_register), .borrow_out_bit(borrow_out_bit), .master_irq_enable(master_irq_enable)
);
`default_nettype wire
